/* sbp_pkg.sv */
/*
 * Package for the six-bit bidirectional port: register indices, widths,
 * reset values, pin drive encodings and function-select encodings.
 * Assumes a 32-bit Avalon-MM slave where each register takes one word.
 */
package sbp_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_PORT_DATA     = 16'hF218;
    localparam logic [15:0] IDX_PORT_DIR      = 16'hF219;
    localparam logic [15:0] IDX_DRIVE_CTL_LO  = 16'hF21A;
    localparam logic [15:0] IDX_DRIVE_CTL_HI  = 16'hF21B;
    localparam logic [15:0] IDX_FUNC_SEL_LO   = 16'hF21C;
    localparam logic [15:0] IDX_FUNC_SEL_HI   = 16'hF21D;

    localparam int          ADDR_W            = 18;
    localparam int          DATA_W            = 32;
    localparam int          PINS              = 6;
    localparam logic [7:0]  REG_RESET         = 8'h00;

    // Direction bit values.
    localparam logic        DIR_OUTPUT        = 1'b0;
    localparam logic        DIR_INPUT         = 1'b1;

    // Drive control pair {high bit, low bit}.
    localparam logic [1:0]  DRV_HIZ           = 2'h0;
    localparam logic [1:0]  DRV_P_OPEN        = 2'h1;
    localparam logic [1:0]  DRV_N_OPEN        = 2'h2;
    localparam logic [1:0]  DRV_CMOS          = 2'h3;
    localparam logic [1:0]  IN_HIZ            = 2'h0;
    localparam logic [1:0]  IN_PULL_DOWN      = 2'h1;
    localparam logic [1:0]  IN_PULL_UP        = 2'h2;

    // Function select pair {high bit, low bit}.
    localparam logic [1:0]  FN_PORT           = 2'h0;
    localparam logic [1:0]  FN_SECONDARY      = 2'h1;
    localparam logic [1:0]  FN_TERTIARY       = 2'h2;

    // Pin carrying the PWM output as its tertiary use.
    localparam int          PWM_PIN           = 4;

    typedef struct packed {
        logic [7:0]        port_data;
        logic [7:0]        port_direction;
        logic [7:0]        drive_ctl_lo;
        logic [7:0]        drive_ctl_hi;
        logic [7:0]        func_sel_lo;
        logic [7:0]        func_sel_hi;
        logic [PINS-1:0]   sync_a;
        logic [PINS-1:0]   sync_b;
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } sbp_state_t;
endpackage

/* sbp_port.sv */
/*
 * Six-bit bidirectional port with data, direction, drive control and
 * function select registers behind an Avalon-MM slave with waitrequest.
 * Assumes pin inputs are asynchronous to SYS_CLK, an external pad model
 * resolves out/enable/pull signals, and the converter and PWM blocks
 * sit outside and reach the pins through this port.
 */
// Our own choice: the Avalon-MM interface to the registers.
// Function
// R1: Output-mode pins drive their data register bit.
// R2: Output-mode data bits read back the written value.
// R3: Input-mode data bits read the current pin level.
// R4: Data bit 0 means low, 1 means high, for outputs and inputs.
// R5: Direction bit 0 selects output, 1 input; output after reset.
// R6: Port data register at index F218, eight bits, reset 00.
// R7: Direction register at index F219, eight bits, reset 00.
// R8: Drive control pair at F21A/F21B, byte access or sixteen-bit pair.
// R9: Function select pair at F21C/F21D, byte access or sixteen-bit pair.
// R10: Pin 0 secondary use is converter oscillation waveform input.
// R11: Pin 1 secondary use is converter reference capacitor connection.
// R12: Pin 2 secondary use is converter reference resistor connection.
// R13: Pin 3 secondary use is converter resistor sensor connection.
// R14: Pin 4 secondary is RC sensor connection, tertiary is PWM output.
// R15: Pin 5 secondary use is converter oscillation monitor output.
// R16: Control pair picks drive in output mode, pull in input mode.
// R17: Bits 7 and 6 read as written and touch no pin.
// R18: Input levels pass a two-flop synchroniser before being read.
`timescale 1ns/1ps
module sbp_port (
    input  wire logic                         SYS_CLK,
    input  wire logic                         RST_N,
    input  wire logic [sbp_pkg::ADDR_W-1:0]   AVS_ADDRESS,
    input  wire logic                         AVS_READ,
    input  wire logic                         AVS_WRITE,
    input  wire logic [sbp_pkg::DATA_W-1:0]   AVS_WRITEDATA,
    input  wire logic [3:0]                   AVS_BYTEENABLE,
    output logic      [sbp_pkg::DATA_W-1:0]   AVS_READDATA,
    output logic                              AVS_WAITREQUEST,
    input  wire logic [sbp_pkg::PINS-1:0]     PIN_IN,
    output logic      [sbp_pkg::PINS-1:0]     PIN_OUT,
    output logic      [sbp_pkg::PINS-1:0]     PIN_OE_N,
    output logic      [sbp_pkg::PINS-1:0]     PIN_PULL_UP,
    output logic      [sbp_pkg::PINS-1:0]     PIN_PULL_DOWN,
    input  wire logic [sbp_pkg::PINS-1:0]     CONV_OUT,
    input  wire logic [sbp_pkg::PINS-1:0]     CONV_OE_N,
    output logic      [sbp_pkg::PINS-1:0]     CONV_PIN_LEVEL,
    output logic                              OSC_WAVE_IN,
    input  wire logic                         PWM_CH_ZERO_OUT
);
    import sbp_pkg::*;

    sbp_state_t            st_q;
    sbp_state_t            st_d;
    logic [ADDR_W-3:0]     word_idx;
    logic                  req;
    logic [PINS-1:0]       pin_level;
    logic [7:0]            data_view;
    logic [DATA_W-1:0]     rd_mux;

    // The word index is the byte address divided by four.
    assign word_idx = AVS_ADDRESS[ADDR_W-1:2];
    assign req      = AVS_READ | AVS_WRITE;
    assign pin_level = st_q.sync_b;

    // One wait state: the request is answered on the second edge it is held.
    assign AVS_WAITREQUEST = req & ~st_q.ack;
    assign AVS_READDATA    = st_q.rdata;

    // Output bits show the register, input bits show the synchronised pin.
    always_comb begin
        data_view = st_q.port_data;
        for (int i = 0; i < PINS; i++) begin
            if (st_q.port_direction[i] == DIR_INPUT) begin
                data_view[i] = pin_level[i];                       // [R3] [R4]
            end
        end                                                        // [R2] [R17]
    end

    // Read multiplexer; unmapped indices return zero.
    always_comb begin
        rd_mux = '0;
        case (word_idx)
            IDX_PORT_DATA[ADDR_W-3:0]: begin
                rd_mux[7:0] = data_view;                           // [R6]
            end
            IDX_PORT_DIR[ADDR_W-3:0]: begin
                rd_mux[7:0] = st_q.port_direction;                 // [R7]
            end
            IDX_DRIVE_CTL_LO[ADDR_W-3:0]: begin
                rd_mux[15:0] = {st_q.drive_ctl_hi, st_q.drive_ctl_lo}; // [R8]
            end
            IDX_DRIVE_CTL_HI[ADDR_W-3:0]: begin
                rd_mux[7:0] = st_q.drive_ctl_hi;
            end
            IDX_FUNC_SEL_LO[ADDR_W-3:0]: begin
                rd_mux[15:0] = {st_q.func_sel_hi, st_q.func_sel_lo};   // [R9]
            end
            IDX_FUNC_SEL_HI[ADDR_W-3:0]: begin
                rd_mux[7:0] = st_q.func_sel_hi;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Next state: bus handshake, register writes and the input synchroniser.
    always_comb begin
        st_d        = st_q;
        st_d.ack    = req & ~st_q.ack;
        st_d.sync_a = PIN_IN;                                      // [R18]
        st_d.sync_b = st_q.sync_a;                                 // [R18]
        if (AVS_READ && !st_q.ack) begin
            st_d.rdata = rd_mux;
        end
        // Writes take effect on the edge where waitrequest is low.
        if (AVS_WRITE && st_q.ack) begin
            case (word_idx)
                IDX_PORT_DATA[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.port_data = AVS_WRITEDATA[7:0];       // [R6]
                    end
                end
                IDX_PORT_DIR[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.port_direction = AVS_WRITEDATA[7:0];  // [R7]
                    end
                end
                IDX_DRIVE_CTL_LO[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.drive_ctl_lo = AVS_WRITEDATA[7:0];    // [R8]
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        st_d.drive_ctl_hi = AVS_WRITEDATA[15:8];   // [R8]
                    end
                end
                IDX_DRIVE_CTL_HI[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.drive_ctl_hi = AVS_WRITEDATA[7:0];    // [R8]
                    end
                end
                IDX_FUNC_SEL_LO[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.func_sel_lo = AVS_WRITEDATA[7:0];     // [R9]
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        st_d.func_sel_hi = AVS_WRITEDATA[15:8];    // [R9]
                    end
                end
                IDX_FUNC_SEL_HI[ADDR_W-3:0]: begin
                    if (AVS_BYTEENABLE[0]) begin
                        st_d.func_sel_hi = AVS_WRITEDATA[7:0];     // [R9]
                    end
                end
                default: begin
                    st_d.ack = st_d.ack;
                end
            endcase
        end
    end

    // State register; every register clears to zero on reset.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;                                // [R5] [R6] [R7] [R8] [R9]
        end else begin
            st_q <= st_d;
        end
    end

    // Per-pin drive, pull and function selection.
    generate
        for (genvar i = 0; i < PINS; i++) begin : g_pin
            logic [1:0] drv;
            logic [1:0] fn;
            logic       val;
            assign drv = {st_q.drive_ctl_hi[i], st_q.drive_ctl_lo[i]};
            assign fn  = {st_q.func_sel_hi[i], st_q.func_sel_lo[i]};
            // Tertiary PWM on pin 4 only; otherwise the port data bit.
            assign val = (i == PWM_PIN && fn == FN_TERTIARY) ?
                         PWM_CH_ZERO_OUT : st_q.port_data[i];      // [R14] [R1]

            always_comb begin
                PIN_OUT[i]       = 1'b0;
                PIN_OE_N[i]      = 1'b1;
                PIN_PULL_UP[i]   = 1'b0;
                PIN_PULL_DOWN[i] = 1'b0;
                if (fn == FN_SECONDARY) begin
                    // Converter owns the pin.
                    PIN_OUT[i]  = CONV_OUT[i];                     // [R10] [R11] [R12]
                    PIN_OE_N[i] = CONV_OE_N[i];                    // [R13] [R14] [R15]
                end else if (st_q.port_direction[i] == DIR_OUTPUT) begin // [R5]
                    case (drv)
                        DRV_CMOS: begin
                            PIN_OUT[i]  = val;                     // [R1] [R4] [R16]
                            PIN_OE_N[i] = 1'b0;
                        end
                        DRV_N_OPEN: begin
                            PIN_OUT[i]  = 1'b0;                    // [R16]
                            PIN_OE_N[i] = val;
                        end
                        DRV_P_OPEN: begin
                            PIN_OUT[i]  = 1'b1;                    // [R16]
                            PIN_OE_N[i] = ~val;
                        end
                        default: begin
                            PIN_OE_N[i] = 1'b1;                    // [R16]
                        end
                    endcase
                end else begin
                    PIN_PULL_UP[i]   = (drv == IN_PULL_UP);        // [R16]
                    PIN_PULL_DOWN[i] = (drv == IN_PULL_DOWN);      // [R16]
                end
            end
        end
    endgenerate

    // Synchronised levels go to the converter; pin 0 is its waveform input.
    assign CONV_PIN_LEVEL = pin_level;
    assign OSC_WAVE_IN    = pin_level[0];                          // [R10]
endmodule

/* sbp_port_assertions.sv */
/* Checker for the six-bit port: wait states, read data hold, synchroniser, pulls.
   Sees only the sbp_port ports and is bound to every instance below. */
`timescale 1ns/1ps
module sbp_port_assertions (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [5:0]  PIN_IN,
    input wire logic [5:0]  PIN_OE_N,
    input wire logic [5:0]  PIN_PULL_UP,
    input wire logic [5:0]  PIN_PULL_DOWN,
    input wire logic [5:0]  CONV_OE_N,
    input wire logic [5:0]  CONV_PIN_LEVEL,
    input wire logic        OSC_WAVE_IN,
    input wire logic        PWM_CH_ZERO_OUT
);
    logic [1:0] up_q;
    // Counts edges after reset so the synchroniser checks skip its fill time.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wait_start_a:
        assert property ((AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE)
            |-> AVS_WAITREQUEST) else $error("no wait state");
    wait_once_a:
        assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("long wait");
    wait_idle_a:
        assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST) else $error("idle wait");
    rdata_hold_a:
        assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
            else $error("read data moved");
    sync_level_a:
        assert property (up_q[1] |-> CONV_PIN_LEVEL == $past(PIN_IN, 2)) else $error("sync");
    osc_wave_a:
        assert property (up_q[1] |-> OSC_WAVE_IN == $past(PIN_IN[0], 2)) else $error("wave");
    pull_excl_a:
        assert property ((PIN_PULL_UP & PIN_PULL_DOWN) == 6'h00) else $error("two pulls");
    drive_by_write_a:
        assert property ($changed(PIN_OE_N) && $stable(CONV_OE_N) && $stable(PWM_CH_ZERO_OUT)
            |-> $past(AVS_WRITE && !AVS_WAITREQUEST)) else $error("drive moved");
endmodule

bind sbp_port sbp_port_assertions sbp_port_assertions_i (.*);

/* sbp_pins_model.sv */
/* Pad model for the six pins: a bench driver wins, then the port's drive,
   then its pulls; a free line wanders. Assumes one clock for the wander. */
`timescale 1ns/1ps
module sbp_pins_model (
    input  wire logic       clk,
    input  wire logic [5:0] out,
    input  wire logic [5:0] oe_n,
    input  wire logic [5:0] pu,
    input  wire logic [5:0] pd,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] lvl
);
    logic [5:0] float_q = 6'h15;
    // A free line flips every cycle so no stale level can read back.
    always @(posedge clk) float_q <= ~float_q;
    // Resolves each pin from its drivers in order of strength.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (ext_en[i]) lvl[i] = ext_val[i];
            else if (!oe_n[i]) lvl[i] = out[i];
            else if (pu[i]) lvl[i] = 1'b1;
            else lvl[i] = pd[i] ? 1'b0 : float_q[i];
        end
    end
endmodule

/* six_bit_bidir_port_tb.sv */
/* Bench for sbp_port: Avalon tasks, drive and pull codes, pin reads and
   function select. Assumes sbp_pins_model on the pin side. */
`timescale 1ns/1ps
module six_bit_bidir_port_tb;
    import sbp_pkg::*;
    logic        SYS_CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic        PWM_CH_ZERO_OUT = 1'b0, AVS_WAITREQUEST, OSC_WAVE_IN;
    logic [17:0] AVS_ADDRESS = 18'h00000;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
    logic [3:0]  AVS_BYTEENABLE = 4'h0;
    logic [5:0]  PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULL_UP, PIN_PULL_DOWN, CONV_PIN_LEVEL;
    logic [5:0]  CONV_OUT = 6'h00, CONV_OE_N = 6'h3F, ext_en = 6'h00, oe;
    logic [7:0]  rd;
    int          num_errors = 0, checked = 0;
    sbp_port sbp_port_i (.*);
    sbp_pins_model sbp_pins_model_i (.clk(SYS_CLK), .out(PIN_OUT), .oe_n(PIN_OE_N),
        .pu(PIN_PULL_UP), .pd(PIN_PULL_DOWN), .ext_en, .ext_val(6'h15), .lvl(PIN_IN));
    // Clock with a 100 ns period.
    always #50 SYS_CLK = ~SYS_CLK;
    // One transfer, held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd,
                       input logic [3:0] be);
        @(posedge SYS_CLK);
        AVS_READ <= ~w;
        AVS_WRITE <= w;
        AVS_ADDRESS <= {idx, 2'h0};
        AVS_WRITEDATA <= {16'h0000, wd};
        AVS_BYTEENABLE <= be;
        @(posedge SYS_CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge SYS_CLK);
        rd = AVS_READDATA[7:0];
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 16'h0000, 4'h1);
        chk(rd, exp);
    endtask
    task automatic print_verdict;
        $display("checked %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Cuts a hang short; the tests need well under two thousand cycles.
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        num_errors++;
        print_verdict;
    end
    // Reset, readback, drive codes in both directions, then alternate functions.
    initial begin
        repeat (4) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 6; i++) rdc(IDX_PORT_DATA + 16'(i), 8'h00);
        chk({2'h0, PIN_OE_N}, 8'h3F);
        $display("test 1 done");
        for (int i = 0; i < 6; i++) bus(1'b1, IDX_PORT_DATA + 16'(i), 16'h00C0 | 16'(i), 4'h1);
        // Pin 0 is now an input with its pull-up on, so its data bit reads high.
        for (int i = 0; i < 6; i++) rdc(IDX_PORT_DATA + 16'(i), 8'hC0 | 8'(i) | 8'(i == 0));
        chk({2'h0, PIN_OE_N}, 8'h3D);
        chk({2'h0, PIN_PULL_UP}, 8'h01);
        bus(1'b1, 16'hF21E, 16'h00FF, 4'h1);
        rdc(16'hF21E, 8'h00);
        $display("test 2 done");
        bus(1'b1, IDX_FUNC_SEL_LO, 16'h0000, 4'h3);
        rdc(IDX_FUNC_SEL_HI, 8'h00);
        bus(1'b1, IDX_PORT_DATA, 16'h002A, 4'h1);
        ext_en <= 6'h3F;
        for (int d = 0; d < 2; d++) begin
            bus(1'b1, IDX_PORT_DIR, d ? 16'h003F : 16'h0000, 4'h1);
            for (int c = 0; c < 4; c++) begin
                bus(1'b1, IDX_DRIVE_CTL_LO, {c[1] ? 8'h3F : 8'h00, c[0] ? 8'h3F : 8'h00}, 4'h3);
                rdc(IDX_PORT_DATA, d ? 8'h15 : 8'h2A);
                oe = (d || c == 0) ? 6'h3F : c == 1 ? 6'h15 : c == 2 ? 6'h2A : 6'h00;
                chk({2'h0, PIN_OE_N}, {2'h0, oe});
                chk({2'h0, PIN_OUT & ~oe}, {2'h0, 6'h2A & ~oe});
                chk({2'h0, PIN_PULL_UP}, (d && c == 2) ? 8'h3F : 8'h00);
                chk({2'h0, PIN_PULL_DOWN}, (d && c == 1) ? 8'h3F : 8'h00);
            end
        end
        $display("test 3 done");
        ext_en <= 6'h00;
        CONV_OE_N <= 6'h3E;
        CONV_OUT <= 6'h01;
        PWM_CH_ZERO_OUT <= 1'b1;
        bus(1'b1, IDX_PORT_DIR, 16'h0000, 4'h1);
        bus(1'b1, IDX_FUNC_SEL_LO, 16'h1001, 4'h3);
        @(posedge SYS_CLK);
        chk({2'h0, PIN_OUT}, 8'h3B);
        CONV_OUT <= 6'h00;
        PWM_CH_ZERO_OUT <= 1'b0;
        @(posedge SYS_CLK);
        chk({2'h0, PIN_OUT}, 8'h2A);
        rdc(IDX_FUNC_SEL_HI, 8'h10);
        $display("test 4 done");
        print_verdict;
    end
endmodule
